// ### design/vcm_pkg.sv
// Purpose: Shared constants and types of the VC-4 path monitor
// Assumes: Byte-wide stream, frame start on the first (trace) byte
// Notes:   Offsets are APB byte addresses
package vcm_pkg;
  // ----------------------------------------
  // Frame geometry and overhead positions
  // ----------------------------------------
  localparam int VC4_COLS  = 261;
  localparam int VC4_ROWS  = 9;
  localparam int POS_B3    = 261;
  localparam int POS_C2    = 522;
  localparam int POS_G1    = 783;
  localparam int TRACE_LEN = 16;
  // ----------------------------------------
  // Persistence counts, in frames and multiframes
  // ----------------------------------------
  localparam int PERSIST     = 5;
  localparam int TIM_PERSIST = 3;
  // ----------------------------------------
  // Byte patterns, G1 and J1 fields
  // ----------------------------------------
  localparam logic [7:0] LABEL_ALL_ONES = 8'hFF;
  localparam logic [7:0] LABEL_UNEQ     = 8'h00;
  localparam logic [3:0] REI_MAX_ERR    = 4'h8;
  localparam int         G1_RDI_BIT     = 3;
  localparam int         J1_ALIGN_BIT   = 7;
  // ----------------------------------------
  // Register offsets, fields, reset values
  // ----------------------------------------
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_DEG    = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_PM     = 8'h0C;
  localparam logic [7:0] OFF_EXP    = 8'h10;
  localparam logic [7:0] OFF_ACC    = 8'h40;
  localparam int CTRL_MON  = 0;
  localparam int CTRL_SSFR = 1;
  localparam int CTRL_RDIR = 2;
  localparam int CTRL_TIMD = 3;
  localparam int CTRL_EXPM = 4;
  localparam int DEG_M_LSB = 16;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] DEG_RST  = 32'h0000_0000;
  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] data;
    logic       clk;
    logic       fs;
    logic       ssf;
  } vcm_stream_type;
  typedef struct packed {
    logic ssf;
    logic rdi;
    logic deg;
    logic tim;
    logic uneq;
  } vcm_cause_type;
endpackage

// ### design/vcm_trace_mem.sv
// Purpose: Small store for the accepted trace bytes
// Assumes: One write and one read port on one clock
// Notes:   Read data comes out of a register, one cycle late
`timescale 1ns/1ns
`default_nettype none
module vcm_trace_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input  wire logic [WIDTH-1:0]         wr_data,
  input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output var  logic [WIDTH-1:0]         rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  // Array write
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Registered read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule // vcm_trace_mem
`default_nettype wire

// ### design/vcm_monitor_sink.sv
// Purpose: Non-intrusive VC-4 path monitor with APB management
// Assumes: Stream pins are asynchronous to pclk, byte rate well below pclk/4
// Notes:   Stream is resampled and passed on unaltered, a few pclk later
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module vcm_monitor_sink #(
  parameter int COLS = vcm_pkg::VC4_COLS,
  parameter int ROWS = vcm_pkg::VC4_ROWS
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output var  logic [31:0]            prdata,
  output var  logic                   pready,
  output var  logic                   pslverr,
  input  wire vcm_pkg::vcm_stream_type in_stream,
  input  wire logic                   one_second_tick,
  input  wire logic                   equipment_defect,
  output var  vcm_pkg::vcm_stream_type out_stream,
  output var  logic                   trail_signal_fail,
  output var  logic                   trail_signal_degrade,
  output var  vcm_pkg::vcm_cause_type fault_cause
);
  localparam int FRAME = COLS * ROWS;
  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (FRAME >= 4096 || FRAME <= vcm_pkg::POS_G1) begin : g_bad_geom
    $error("frame size not served by the position counter");
  end

  // ----------------------------------------
  // Stream synchroniser and pass-through
  // ----------------------------------------
  vcm_pkg::vcm_stream_type s1, s2;
  logic clk_q;
  wire byte_stb = s2.clk & ~clk_q;

  // Two-flop sampling of the stream pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= '0;
      s2 <= '0;
      clk_q <= 1'b0;
    end else begin
      s1 <= in_stream;
      s2 <= s1;
      clk_q <= s2.clk;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_stream <= '0;
    end else begin
      out_stream <= s2;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [31:0]  ctrl, deg_cfg;
  logic [127:0] exp_trace;
  logic [4:0]   ddef;                 // ais, uneq, tim, deg, rdi
  logic [15:0]  near_acc, far_acc, near_block_count, far_block_count;
  logic         near_defect_second, far_defect_second;
  wire mon          = ctrl[vcm_pkg::CTRL_MON];  // qualifier
  wire tim_dis      = ctrl[vcm_pkg::CTRL_TIMD];
  wire path_alarm   = ddef[4];
  wire unequipped   = ddef[3];
  wire mismatch     = ddef[2];
  wire degraded     = ddef[1];
  wire remote       = ddef[0];
  wire ssf_now      = s2.ssf;
  wire fail_or_ais  = ssf_now | path_alarm;

  // ----------------------------------------
  // Frame position, parity, overhead capture
  // ----------------------------------------
  logic [11:0] pos;
  logic [7:0]  bip_acc, prev_bip;
  logic        seen_fs, bip_valid;
  wire  [11:0] cur_pos = s2.fs ? 12'h000 :
                         (pos == 12'(FRAME - 1)) ? 12'h000 : 12'(pos + 12'h001);
  wire at_j1 = byte_stb & s2.fs;
  wire at_b3 = byte_stb & (cur_pos == 12'(vcm_pkg::POS_B3));
  wire at_c2 = byte_stb & (cur_pos == 12'(vcm_pkg::POS_C2));
  wire at_g1 = byte_stb & (cur_pos == 12'(vcm_pkg::POS_G1));
  // compare B3 with parity of the previous frame
  wire near_ev = at_b3 & bip_valid & (s2.data != prev_bip);
  // codes one to eight count one block; low bits unused here, bit 3 is remote
  wire [3:0] rei   = s2.data[7:4];
  wire far_ev      = at_g1 & (rei != 4'h0) & (rei <= vcm_pkg::REI_MAX_ERR);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos <= '0;
      bip_acc <= '0;
      prev_bip <= '0;
      seen_fs <= 1'b0;
      bip_valid <= 1'b0;
    end else if (byte_stb) begin
      pos <= cur_pos;
      bip_acc <= s2.fs ? s2.data : (bip_acc ^ s2.data);
      if (s2.fs) begin
        prev_bip <= bip_acc;
        seen_fs <= 1'b1;
        bip_valid <= seen_fs;
      end
    end
  end

  // ----------------------------------------
  // Trace recovery and mismatch
  // ----------------------------------------
  logic [3:0] tr_idx;
  logic       mm_acc;
  wire  [3:0] next_idx = s2.data[vcm_pkg::J1_ALIGN_BIT] ? 4'h0 : 4'(tr_idx + 4'h1);
  wire  [7:0] exp_byte = exp_trace[{next_idx, 3'b000} +: 8];
  wire        byte_chk = ~ctrl[vcm_pkg::CTRL_EXPM] | (next_idx == 4'h0);
  wire        byte_bad = byte_chk & (s2.data != exp_byte);
  wire        mf_end   = at_j1 & (next_idx == 4'h0);
  wire [7:0]  acc_rd;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tr_idx <= '0;
      mm_acc <= 1'b0;
    end else if (at_j1) begin
      tr_idx <= next_idx;
      mm_acc <= mf_end ? byte_bad : (mm_acc | byte_bad);
    end
  end

  // accepted trace store, read by management
  vcm_trace_mem #(.WIDTH(8), .DEPTH(vcm_pkg::TRACE_LEN)) u_trace (
    .clk     (pclk),
    .rst_n   (presetn),
    .wr_en   (at_j1),
    .wr_addr (next_idx),
    .wr_data (s2.data),
    .rd_addr (paddr[5:2]),
    .rd_data (acc_rd)
  );

  // ----------------------------------------
  // Persistence filters: ais, uneq, tim, rdi
  // ----------------------------------------
  logic [3:0] f_stb, f_hit, f_kill, f_st;
  logic [2:0] f_cnt [4];
  // label drives alarm and unequipped; bit 3 is remote
  assign f_stb  = {at_c2, at_c2, mf_end, at_g1};
  assign f_hit  = {s2.data == vcm_pkg::LABEL_ALL_ONES, s2.data == vcm_pkg::LABEL_UNEQ,
                   mm_acc, s2.data[vcm_pkg::G1_RDI_BIT]};
  // fail or alarm clears uneq, tim and rdi; disable clears mismatch
  assign f_kill = {1'b0, fail_or_ais, fail_or_ais | tim_dis, fail_or_ais};

  for (genvar i = 0; i < 4; i++) begin : g_filt
    localparam logic [2:0] LIM = (i == 1) ? 3'(vcm_pkg::TIM_PERSIST - 1) : 3'(vcm_pkg::PERSIST - 1);
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        f_st[i] <= 1'b0;
        f_cnt[i] <= '0;
      end else if (f_kill[i]) begin
        f_st[i] <= 1'b0;
        f_cnt[i] <= '0;
      end else if (f_stb[i]) begin
        if (f_hit[i] != f_st[i]) begin
          f_st[i] <= (f_cnt[i] == LIM) ? f_hit[i] : f_st[i];
          f_cnt[i] <= (f_cnt[i] == LIM) ? 3'h0 : 3'(f_cnt[i] + 3'h1);
        end else begin
          f_cnt[i] <= '0;
        end
      end
    end
  end

  // ----------------------------------------
  // Degrade and one-second monitoring
  // ----------------------------------------
  logic [3:0] deg_run;
  logic       deg_st, ssf_sec, ns_acc, fs_acc;
  wire [15:0] deg_thr   = deg_cfg[15:0];
  wire [3:0]  deg_m     = deg_cfg[vcm_pkg::DEG_M_LSB +: 4];
  wire [15:0] near_next = 16'(near_acc + {15'h0000, near_ev});
  wire [15:0] far_next  = 16'(far_acc + {15'h0000, far_ev});
  wire        bad_sec   = (deg_thr != 16'h0000) & (near_next >= deg_thr);
  wire        tsf_now   = fail_or_ais | unequipped | mismatch;
  wire        run_done  = (4'(deg_run + 4'h1) >= deg_m);

  // degraded over consecutive seconds, failed seconds skipped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      deg_run <= '0;
      deg_st <= 1'b0;
      ssf_sec <= 1'b0;
    end else if (one_second_tick) begin
      ssf_sec <= fail_or_ais;
      if (!(ssf_sec | fail_or_ais) && deg_m != 4'h0) begin
        if (bad_sec != deg_st) begin
          deg_st <= run_done ? bad_sec : deg_st;
          deg_run <= run_done ? 4'h0 : 4'(deg_run + 4'h1);
        end else begin
          deg_run <= '0;
        end
      end
    end else begin
      ssf_sec <= ssf_sec | fail_or_ais;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      near_acc <= '0;
      far_acc <= '0;
      ns_acc <= 1'b0;
      fs_acc <= 1'b0;
      near_block_count <= '0;
      far_block_count <= '0;
      near_defect_second <= 1'b0;
      far_defect_second <= 1'b0;
    end else if (one_second_tick) begin
      near_block_count <= near_next;
      far_block_count <= far_next;
      near_defect_second <= ns_acc | tsf_now | equipment_defect;
      far_defect_second <= fs_acc | remote;
      near_acc <= '0;
      far_acc <= '0;
      ns_acc <= 1'b0;
      fs_acc <= 1'b0;
    end else begin
      near_acc <= near_next;       // one block per frame
      far_acc <= far_next;
      ns_acc <= ns_acc | tsf_now | equipment_defect;
      fs_acc <= fs_acc | remote;
    end
  end

  // ----------------------------------------
  // Defect, consequent actions, fault causes
  // ----------------------------------------
  // actions and causes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ddef <= '0;
      trail_signal_fail <= 1'b0;
      trail_signal_degrade <= 1'b0;
      fault_cause <= '0;
    end else begin
      ddef <= {f_st[3], f_st[2], f_st[1], deg_st, f_st[0]};
      trail_signal_fail <= tsf_now;
      trail_signal_degrade <= degraded;
      fault_cause.ssf <= mon & ctrl[vcm_pkg::CTRL_SSFR] & fail_or_ais;
      fault_cause.rdi <= mon & ctrl[vcm_pkg::CTRL_RDIR] & remote & ~unequipped & ~mismatch;
      fault_cause.deg <= mon & degraded & ~mismatch;
      fault_cause.tim <= mon & mismatch & ~unequipped;
      fault_cause.uneq <= mon & unequipped;
    end
  end

  // ----------------------------------------
  // APB slave, one wait state on every access
  // ----------------------------------------
  wire acc_fire = psel & penable & pready;
  wire wr_fire  = acc_fire & pwrite;
  wire is_exp   = (paddr[7:4] == vcm_pkg::OFF_EXP[7:4]);
  wire is_acc   = (paddr[7:6] == vcm_pkg::OFF_ACC[7:6]);
  wire is_ctrl  = (paddr == vcm_pkg::OFF_CTRL);
  wire is_deg   = (paddr == vcm_pkg::OFF_DEG);
  wire is_stat  = (paddr == vcm_pkg::OFF_STATUS);
  wire is_pm    = (paddr == vcm_pkg::OFF_PM);
  wire ro_hit   = is_stat | is_pm | is_acc;
  wire wr_hit   = is_ctrl | is_deg | is_exp;
  wire bad_addr = ~(ro_hit | wr_hit) | (paddr[1:0] != 2'b00);
  wire [31:0] stat_word = {18'h00000, trail_signal_degrade, trail_signal_fail,
                           fault_cause, ddef, near_defect_second, far_defect_second};
  wire [31:0] rd_word = is_ctrl ? ctrl :
                        is_deg  ? deg_cfg :
                        is_stat ? stat_word :
                        is_pm   ? {far_block_count, near_block_count} :
                        is_exp  ? exp_trace[{paddr[3:2], 5'b00000} +: 32] :
                        is_acc  ? {24'h000000, acc_rd} : 32'h0000_0000;

  // Answer in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & bad_addr;
      prdata <= (psel & penable & ~pready & ~pwrite & ~bad_addr) ? rd_word : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= vcm_pkg::CTRL_RST;
      deg_cfg <= vcm_pkg::DEG_RST;
      exp_trace <= '0;
    end else if (wr_fire & ~bad_addr) begin
      if (is_ctrl) ctrl <= {27'h0000000, pwdata[4:0]};
      if (is_deg) deg_cfg <= {12'h000, pwdata[19:0]};
      if (is_exp) exp_trace[{paddr[3:2], 5'b00000} +: 32] <= pwdata;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_b3_error;
    @(posedge pclk) disable iff (!presetn)
      (at_b3 && bip_valid && s2.data != prev_bip && !one_second_tick) |=> (near_acc == $past(near_acc) + 16'h0001);
  endproperty
  a_b3_error: assert property (p_b3_error) else $error("parity error not counted");
  property p_rei_none;
    @(posedge pclk) disable iff (!presetn) (at_g1 && s2.data[7:4] >= 4'h9) |-> !far_ev;
  endproperty
  a_rei_none: assert property (p_rei_none) else $error("REI code above eight counted");
  property p_ais_set;
    @(posedge pclk) disable iff (!presetn) $rose(f_st[3]) |-> $past(f_cnt[3]) == 3'h4;
  endproperty
  a_ais_set: assert property (p_ais_set) else $error("alarm set too early");
  property p_ais_clr;
    @(posedge pclk) disable iff (!presetn) $fell(f_st[3]) |-> $past(f_cnt[3]) == 3'h4;
  endproperty
  a_ais_clr: assert property (p_ais_clr) else $error("alarm cleared too early");
  property p_tim_dis;
    @(posedge pclk) disable iff (!presetn) tim_dis |=> ##1 !mismatch;
  endproperty
  a_tim_dis: assert property (p_tim_dis) else $error("mismatch while disabled");
  sequence s_fail_seen;
    fail_or_ais && mon && ctrl[vcm_pkg::CTRL_SSFR];
  endsequence
  property p_ssf_cause;
    @(posedge pclk) disable iff (!presetn) s_fail_seen |=> fault_cause.ssf;
  endproperty
  a_ssf_cause: assert property (p_ssf_cause) else $error("fail cause missing");
  property p_mon_off;
    @(posedge pclk) disable iff (!presetn) !mon [*2] |-> fault_cause == '0;
  endproperty
  a_mon_off: assert property (p_mon_off) else $error("cause reported while not monitored");
  property p_tsf;
    @(posedge pclk) disable iff (!presetn) unequipped |=> trail_signal_fail;
  endproperty
  a_tsf: assert property (p_tsf) else $error("trail fail missing on unequipped");
  property p_pm_latch;
    @(posedge pclk) disable iff (!presetn) one_second_tick |=> near_acc == 16'h0000 && far_acc == 16'h0000;
  endproperty
  a_pm_latch: assert property (p_pm_latch) else $error("second sums not restarted");
  property p_pass;
    @(posedge pclk) disable iff (!presetn) ##1 out_stream == $past(s2);
  endproperty
  a_pass: assert property (p_pass) else $error("stream altered");
endmodule // vcm_monitor_sink
`default_nettype wire

// ### testbench/vcm_path_source.sv
// Purpose: Upstream VC-4 path source model
// Assumes: 400 ns byte clock, byte stable at rising edge
// Notes:   Clock stands still between frames
`timescale 1ns/1ns
`default_nettype none
module vcm_path_source #(
  parameter int LEN = 784
) (
  output var vcm_pkg::vcm_stream_type stream
);
  // ----
  // Frame builder
  // ----
  logic [7:0] par = 8'h00;
  logic [3:0] idx = 4'h0;
  initial stream = '0;
  // Send one frame of overhead and filler
  task automatic send_frame(input logic [7:0] c2, input logic [7:0] g1, input logic err);
    logic [7:0] b;
    logic [7:0] acc;
    acc = 8'h00;
    b = 8'h00;
    #13;
    for (int p = 0; p < LEN; p++) begin
      case (p)
        0: b = {idx == 4'h0, 3'b100, idx};  // Trace byte
        vcm_pkg::POS_B3: b = par ^ {7'h00, err};
        vcm_pkg::POS_C2: b = c2;
        vcm_pkg::POS_G1: b = g1;
        default: b = p[7:0] ^ 8'h5A;
      endcase
      acc = acc ^ b;
      stream.data = b;
      stream.fs = (p == 0);
      #200 stream.clk = 1'b1;
      #200 stream.clk = 1'b0;
    end
    par = acc;
    idx = idx + 4'h1;
    // Idle line shows no stale byte
    stream.data = ~b;
    stream.fs = 1'b0;
  endtask
endmodule // vcm_path_source
`default_nettype wire

// ### testbench/vcm_monitor_sink_tb_top.sv
// Purpose: Bench for the VC-4 path monitor
// Assumes: Short frames of 196 x 4 bytes
// Notes:   Scenarios share one running stream
`timescale 1ns/1ns
`default_nettype none
module vcm_monitor_sink_tb_top;
  // ----
  // Signals
  // ----
  logic                    pclk, presetn, psel, penable, pwrite, rerr;
  logic [7:0]              paddr;
  logic [31:0]             pwdata, prdata, rdata;
  logic                    pready, pslverr, one_second_tick, equipment_defect;
  logic                    trail_signal_fail, trail_signal_degrade;
  vcm_pkg::vcm_stream_type in_stream, out_stream, d1, d2, d3;
  vcm_pkg::vcm_cause_type  fault_cause;
  int                      failures = 0;
  int                      num_checks = 0;
  int                      cycles = 0;

  vcm_monitor_sink #(.COLS(196), .ROWS(4)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .in_stream(in_stream),
    .one_second_tick(one_second_tick), .equipment_defect(equipment_defect),
    .out_stream(out_stream), .trail_signal_fail(trail_signal_fail),
    .trail_signal_degrade(trail_signal_degrade), .fault_cause(fault_cause));
  vcm_path_source #(.LEN(784)) src (.stream(in_stream));

  // Clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // Stream delay line and run limit
  always @(posedge pclk) begin
    d1 <= in_stream;
    d2 <= d1;
    d3 <= d2;
    cycles <= cycles + 1;
    if (cycles == 100000) begin
      failures++;
      final_report();
    end
  end
  always @(negedge pclk) begin
    if (presetn === 1'b1) chk(32'(out_stream), 32'(d3));
  end
  // ----
  // Helpers
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // APB transfer held until ready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk({31'h0, pready}, 32'h1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    repeat (3) @(posedge pclk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(rdata & m, x);
  endtask
  task automatic tick;
    @(posedge pclk);
    one_second_tick <= 1'b1;
    @(posedge pclk);
    one_second_tick <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask
  task automatic final_report;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ----
  // Scenarios
  // ----
  task automatic s_reset;
    rd_chk(vcm_pkg::OFF_CTRL, 32'hFFFFFFFF, 32'h0);
    rd_chk(vcm_pkg::OFF_DEG, 32'hFFFFFFFF, 32'h0);
    apb(1'b0, 8'h24, 32'h0);
    chk({rdata[30:0], rerr}, 32'h1);
    chk({27'h0, fault_cause}, 32'h0);
    wr(vcm_pkg::OFF_CTRL, 32'h0A);
    wr(vcm_pkg::OFF_DEG, 32'h0001_0001);
  endtask
  // All-ones label sets alarm on fifth frame
  task automatic s_alarm;
    for (int k = 0; k < 5; k++) begin
      if (k == 4) rd_chk(vcm_pkg::OFF_STATUS, 32'h40, 32'h0);
      src.send_frame(8'hFF, 8'h07, 1'b0);
    end
    repeat (8) @(posedge pclk);
    rd_chk(vcm_pkg::OFF_STATUS, 32'h40, 32'h40);
    chk({31'h0, trail_signal_fail}, 32'h1);
    chk({27'h0, fault_cause}, 32'h0);
    wr(vcm_pkg::OFF_CTRL, 32'h0B);
    chk({27'h0, fault_cause}, 32'h10);
    rd_chk(vcm_pkg::OFF_ACC, 32'hFF, 32'hC0);
    rd_chk(8'h4C, 32'hFF, 32'h43);
    tick();
    rd_chk(vcm_pkg::OFF_STATUS, 32'h3, 32'h2);
  endtask
  // Other labels clear alarm on fifth frame
  task automatic s_clear;
    for (int k = 0; k < 5; k++) begin
      if (k == 4) rd_chk(vcm_pkg::OFF_STATUS, 32'h40, 32'h40);
      src.send_frame(8'h13, (k == 4) ? 8'h0F : 8'h07, 1'b0);
    end
    repeat (8) @(posedge pclk);
    rd_chk(vcm_pkg::OFF_STATUS, 32'h1040, 32'h0);
    tick();
  endtask
  // Block counts, remote defect, degrade
  task automatic s_perf;
    src.send_frame(8'h13, 8'h8F, 1'b1);
    @(posedge pclk);
    equipment_defect <= 1'b1;
    src.send_frame(8'h13, 8'h9F, 1'b0);
    @(posedge pclk);
    equipment_defect <= 1'b0;
    src.send_frame(8'h13, 8'h1F, 1'b0);
    src.send_frame(8'h13, 8'h0F, 1'b0);
    repeat (8) @(posedge pclk);
    rd_chk(vcm_pkg::OFF_STATUS, 32'h14, 32'h4);
    chk({27'h0, fault_cause}, 32'h0);
    wr(vcm_pkg::OFF_CTRL, 32'h0F);
    chk({27'h0, fault_cause}, 32'h08);
    tick();
    rd_chk(vcm_pkg::OFF_PM, 32'hFFFFFFFF, 32'h0002_0001);
    rd_chk(vcm_pkg::OFF_STATUS, 32'h3, 32'h3);
    chk({30'h0, trail_signal_degrade, trail_signal_fail}, 32'h2);
    chk({27'h0, fault_cause}, 32'h0C);
  endtask
  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    one_second_tick = 1'b0;
    equipment_defect = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    s_reset();
    s_alarm();
    s_clear();
    s_perf();
    final_report();
  end
endmodule // vcm_monitor_sink_tb_top
`default_nettype wire
